// ===== pkg/dpc_regs.svh
`ifndef DPC_REGS_SVH
`define DPC_REGS_SVH

// Register byte offsets on the APB
`define DPC_ADDR_W 8
`define DPC_OFF_SRC 8'h00
`define DPC_OFF_EDGE 8'h04
`define DPC_OFF_ARM 8'h08
`define DPC_OFF_STAT 8'h0C
`define DPC_OFF_PACT1 8'h10
`define DPC_OFF_PACT2 8'h14
`define DPC_OFF_PREF1 8'h18
`define DPC_OFF_PREF2 8'h1C
`define DPC_OFF_IRQ_STAT 8'h20
`define DPC_OFF_IRQ_MASK 8'h24

// Reset values
`define DPC_SRC_RST 16'h0004
`define DPC_EDGE_RST 16'h0001
`define DPC_ARM_RST 16'h0000
`define DPC_LATCH_RST 32'h0000_0000
`define DPC_IRQ_RST 2'h0

// Field positions
`define DPC_SRC_CH1_LSB 0
`define DPC_SRC_CH2_LSB 2
`define DPC_ARM_CANCEL_BIT 14
`define DPC_ARM_REPEAT_BIT 15
`define DPC_NUM_CH 2
`define DPC_NUM_PINS 4

`endif

// ===== pkg/dpc_pkg.sv
`default_nettype none
package dpc_pkg;

  typedef enum logic [1:0] {
    DPC_SRC_CAP1 = 2'b00,
    DPC_SRC_CAP2 = 2'b01,
    DPC_SRC_SP_IDX = 2'b10,
    DPC_SRC_ACT_IDX = 2'b11
  } dpc_src_e;

  typedef enum logic {
    DPC_IDLE = 1'b0,
    DPC_RUN = 1'b1
  } dpc_run_e;

  typedef struct packed {
    logic rise;
    logic fall;
  } dpc_edge_s;

  typedef struct packed {
    logic repeat_mode;
    logic cancel;
    logic [11:0] rsvd;
    logic [1:0] start;
  } dpc_arm_s;

endpackage
`default_nettype wire

// ===== hw/dpc_edge_det.sv
`timescale 1ns/100ps
`default_nettype none
module dpc_edge_det
  import dpc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Asynchronous pin
  input wire logic pin,
  // Edge pulses, one cycle each
  output dpc_edge_s edge_o
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Two stages before anything looks at the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // One driver for the whole struct: rise first, then fall
  assign edge_o = {s2_q & ~s3_q, ~s2_q & s3_q};

endmodule // dpc_edge_det
`default_nettype wire

// ===== hw/dpc_capture.sv
`timescale 1ns/100ps
`default_nettype none
`include "dpc_regs.svh"

// How it works
// - Two independent channels; source fields are bits 1..0 and 3..2.
// - Source codes: 00 input one, 01 input two, 10 setpoint, 11 actual index.
// - Code 10 needs setpoint encoder slot fitted; code 11 needs actual slot.
// - Edge select bit per channel: 0 falling, 1 rising edge triggers.
// - Writing 1 to start bit 0 or 1 re-arms channel; 0 changes nothing.
// - Start write with bit 14 set cancels the addressed channels.
// - Bit 15 picks single capture (0) or continuous capture (1).
// - Status bits 0 and 1 show whether each channel is running.
// - Each trigger latches signed actual position into channel's register.
// - Each trigger latches signed gearbox setpoint into channel's register.
module dpc_capture
  import dpc_pkg::*;
(
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`DPC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Trigger pins
  input wire logic capture_input_one,
  input wire logic capture_input_two,
  input wire logic setpoint_index,
  input wire logic actual_index,
  // Encoder slot presence
  input wire logic setpoint_encoder_slot_fitted,
  input wire logic actual_encoder_slot_fitted,
  // Position feeds, same clock
  input wire logic signed [31:0] actual_position,
  input wire logic signed [31:0] gearbox_setpoint,
  // Interrupt
  output logic irq
);

  localparam int NCH = `DPC_NUM_CH;
  localparam int NPIN = `DPC_NUM_PINS;

  logic [15:0] src_q;
  logic [15:0] edge_q;
  logic [15:0] arm_q;
  dpc_run_e run_q [NCH];
  logic [NCH-1:0] rep_q;
  logic signed [31:0] pact_q [NCH];
  logic signed [31:0] pref_q [NCH];
  logic [NCH-1:0] ist_q;
  logic [NCH-1:0] mask_q;
  logic [1:0] fit_s1_q;
  logic [1:0] fit_s2_q;
  logic [NPIN-1:0] pin_vec;
  wire dpc_edge_s [NPIN-1:0] pin_edge;
  dpc_edge_s [NCH-1:0] sel_edge;
  logic [NCH-1:0] trig;
  logic [NCH-1:0] running;
  logic [NCH-1:0] arm_hit;
  logic [NCH-1:0] ist_d;
  logic [31:0] rd_data;
  logic rd_err;
  logic acc_done;
  logic wr_en;
  logic arm_wr;
  dpc_arm_s arm_d;

  // Byte-lane merge for the 16-bit control registers
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) begin
      r[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // Source decode with slot gating
  function automatic dpc_edge_s pick_edge(input dpc_src_e src,
                                          input dpc_edge_s [NPIN-1:0] e,
                                          input logic [1:0] fit);
    dpc_edge_s r;
    r = '0;
    unique case (src)
      DPC_SRC_CAP1: r = e[0];
      DPC_SRC_CAP2: r = e[1];
      DPC_SRC_SP_IDX: r = fit[0] ? e[2] : '0;
      DPC_SRC_ACT_IDX: r = fit[1] ? e[3] : '0;
    endcase
    return r;
  endfunction

  assign pin_vec = {actual_index, setpoint_index, capture_input_two,
                    capture_input_one};

  for (genvar i = 0; i < NPIN; i++) begin : g_pin
    dpc_edge_det u_edge (
      .pclk(pclk),
      .presetn(presetn),
      .pin(pin_vec[i]),
      .edge_o(pin_edge[i])
    );
  end

  // Slot presence is a slow level, plain two-stage sync
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fit_s1_q <= 2'h0;
      fit_s2_q <= 2'h0;
    end else begin
      fit_s1_q <= {actual_encoder_slot_fitted, setpoint_encoder_slot_fitted};
      fit_s2_q <= fit_s1_q;
    end
  end

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      sel_edge[c] = pick_edge(dpc_src_e'(src_q[2*c +: 2]), pin_edge,
                              fit_s2_q);
      running[c] = (run_q[c] == DPC_RUN);
      trig[c] = running[c] &
                (edge_q[c] ? sel_edge[c].rise : sel_edge[c].fall);
    end
  end

  // APB: one wait state, so every access takes setup plus two cycles
  assign acc_done = psel & penable & pready;
  assign wr_en = acc_done & pwrite;
  assign arm_wr = wr_en & (paddr == `DPC_OFF_ARM);
  assign arm_d = dpc_arm_s'(merge16(arm_q, pwdata, pstrb));
  assign arm_hit = arm_wr ? arm_d.start : 2'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= rd_err;
      prdata <= pwrite ? 32'h0000_0000 : rd_data;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr)
      `DPC_OFF_SRC: rd_data = {16'h0000, src_q};
      `DPC_OFF_EDGE: rd_data = {16'h0000, edge_q};
      `DPC_OFF_ARM: rd_data = {16'h0000, arm_q};
      `DPC_OFF_STAT: rd_data = {30'h0000_0000, running};
      `DPC_OFF_PACT1: rd_data = pact_q[0];
      `DPC_OFF_PACT2: rd_data = pact_q[1];
      `DPC_OFF_PREF1: rd_data = pref_q[0];
      `DPC_OFF_PREF2: rd_data = pref_q[1];
      `DPC_OFF_IRQ_STAT: rd_data = {30'h0000_0000, ist_q};
      `DPC_OFF_IRQ_MASK: rd_data = {30'h0000_0000, mask_q};
      default: rd_err = 1'b1;
    endcase
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= `DPC_SRC_RST;
      edge_q <= `DPC_EDGE_RST;
      arm_q <= `DPC_ARM_RST;
      mask_q <= `DPC_IRQ_RST;
    end else if (wr_en) begin
      if (paddr == `DPC_OFF_SRC) begin
        src_q <= merge16(src_q, pwdata, pstrb);
      end
      if (paddr == `DPC_OFF_EDGE) begin
        edge_q <= merge16(edge_q, pwdata, pstrb);
      end
      if (paddr == `DPC_OFF_ARM) begin
        arm_q <= arm_d;
      end
      if (paddr == `DPC_OFF_IRQ_MASK && pstrb[0]) begin
        mask_q <= pwdata[1:0];
      end
    end
  end

  // Channel run state; a software start or cancel beats a trigger
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NCH; c++) begin
        run_q[c] <= DPC_IDLE;
      end
      rep_q <= 2'h0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (arm_hit[c]) begin
          run_q[c] <= arm_d.cancel ? DPC_IDLE : DPC_RUN;
          rep_q[c] <= arm_d.repeat_mode;
        end else if (trig[c] && !rep_q[c]) begin
          run_q[c] <= DPC_IDLE;
        end
      end
    end
  end

  // Position latches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NCH; c++) begin
        pact_q[c] <= `DPC_LATCH_RST;
        pref_q[c] <= `DPC_LATCH_RST;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (trig[c]) begin
          pact_q[c] <= actual_position;
          pref_q[c] <= gearbox_setpoint;
        end
      end
    end
  end

  // Sticky capture events; a new event wins over a write-one clear
  always_comb begin
    ist_d = ist_q;
    if (wr_en && paddr == `DPC_OFF_IRQ_STAT && pstrb[0]) begin
      ist_d = ist_d & ~pwdata[1:0];
    end
    ist_d = ist_d | trig;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q <= `DPC_IRQ_RST;
      irq <= 1'b0;
    end else begin
      ist_q <= ist_d;
      irq <= |(ist_d & mask_q);
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_single_hit(int c);
    trig[c] && !rep_q[c] && !arm_hit[c];
  endsequence

  sequence s_cancel(int c);
    arm_hit[c] && arm_d.cancel;
  endsequence

  ch1_source_a: assert property (
    running[0] && src_q[1:0] == 2'b01 && edge_q[0] && pin_edge[1].rise
    |=> pact_q[0] == $past(actual_position))
    else $error("channel one missed capture input two");

  ch2_source_a: assert property (
    running[1] && src_q[3:2] == 2'b00 && !edge_q[1] && pin_edge[0].fall
    |=> pref_q[1] == $past(gearbox_setpoint))
    else $error("channel two missed capture input one");

  slot_gate_a: assert property (
    src_q[1:0] == 2'b10 && !fit_s2_q[0] |-> !trig[0])
    else $error("setpoint index used without fitted slot");

  edge_pol_a: assert property (
    !edge_q[1] && sel_edge[1].rise && !sel_edge[1].fall |-> !trig[1])
    else $error("falling-edge channel fired on a rising edge");

  arm_start_a: assert property (
    arm_hit[0] && !arm_d.cancel |=> running[0] ##1
    (running[0] || $past(trig[0]) || $past(arm_hit[0])))
    else $error("channel one not running after start");

  arm_zero_a: assert property (
    arm_wr && !arm_d.start[1] && !trig[1] |=> $stable(run_q[1]))
    else $error("zero start bit changed channel two");

  cancel_a: assert property (
    s_cancel(1) |=> !running[1] && !trig[1])
    else $error("cancel left channel two running");

  repeat_a: assert property (
    trig[0] && rep_q[0] && !arm_hit[0] |=> running[0])
    else $error("continuous channel one stopped after capture");

  status_read_a: assert property (
    psel && penable && !pready && !pwrite && paddr == `DPC_OFF_STAT
    |=> prdata[1:0] == $past(running))
    else $error("status read does not show running bits");

  single_a: assert property (
    s_single_hit(0) |=> !running[0] ##1 $stable(pact_q[0]))
    else $error("single capture kept channel one running");

  irq_set_a: assert property (
    trig[1] |=> ist_q[1] ##0 (irq || !$past(mask_q[1])))
    else $error("capture event lost from interrupt status");

  slot_gate_two_a: assert property (
    src_q[3:2] == 2'b11 && !fit_s2_q[1] |-> !trig[1])
    else $error("actual index used without fitted slot");

  latch_hold_a: assert property (
    !trig[1] |=> $stable(pact_q[1]) && $stable(pref_q[1]))
    else $error("channel two latch changed without trigger");

  single_two_a: assert property (
    s_single_hit(1) |=> !running[1])
    else $error("single capture kept channel two running");

  pready_pulse_a: assert property (
    pready |=> !pready)
    else $error("ready held longer than one cycle");

  irq_level_a: assert property (
    1'b1 |=> irq == |(ist_q & $past(mask_q)))
    else $error("interrupt output disagrees with status and mask");

endmodule // dpc_capture
`default_nettype wire

// ===== tb/dpc_pins_model.sv
`timescale 1ns/100ps
`default_nettype none
module dpc_pins_model (
  // Clock
  input wire logic pclk,
  // Trigger pins, idle low
  output logic cap_one,
  output logic cap_two,
  output logic sp_idx,
  output logic act_idx
);
  logic [3:0] pin_q = 4'h0;
  assign {act_idx, sp_idx, cap_two, cap_one} = pin_q;
  // Whole pulse, so either edge polarity sees exactly one event
  task automatic pulse(input logic [1:0] idx);
    @(posedge pclk);
    pin_q[idx] <= 1'b1;
    repeat (4) @(posedge pclk);
    pin_q[idx] <= 1'b0;
    // Room for the sync flops before the bench reads back
    repeat (8) @(posedge pclk);
  endtask
endmodule // dpc_pins_model
`default_nettype wire

// ===== tb/dpc_capture_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "dpc_regs.svh"
module dpc_capture_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdv;
  logic pready, pslverr, irq, err;
  logic sp_fit = 1'b1;
  logic act_fit = 1'b1;
  logic signed [31:0] pos = 32'sh0;
  logic signed [31:0] gb = 32'sh0;
  logic c1, c2, si, ai;
  int miscompares = 0;
  int n_tests = 0;

  initial begin
    forever #5 pclk = ~pclk;
  end

  dpc_capture uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_input_one(c1), .capture_input_two(c2), .setpoint_index(si),
    .actual_index(ai), .setpoint_encoder_slot_fitted(sp_fit),
    .actual_encoder_slot_fitted(act_fit), .actual_position(pos),
    .gearbox_setpoint(gb), .irq(irq));

  dpc_pins_model m (.pclk(pclk), .cap_one(c1), .cap_two(c2),
    .sp_idx(si), .act_idx(ai));

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No fixed latency assumed; the watchdog bounds this
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  // Position held steady over the pulse so the latch value is exact
  task automatic cap(input logic [1:0] pin, input logic [31:0] p,
                     input logic [7:0] pa, input logic [7:0] pr);
    pos <= p;
    gb <= ~p;
    m.pulse(pin);
    rd(pa, p);
    rd(pr, ~p);
  endtask

  task results;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    results;
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(`DPC_OFF_SRC, 32'h4);
    rd(`DPC_OFF_EDGE, 32'h1);
    rd(`DPC_OFF_ARM, 32'h0);
    rd(`DPC_OFF_STAT, 32'h0);
    rd(8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(`DPC_OFF_IRQ_MASK, 32'h1);
    // Channel one, single shot, every source code in turn
    for (logic [31:0] s = 0; s < 4; s++) begin
      wr(`DPC_OFF_SRC, s);
      wr(`DPC_OFF_ARM, 32'h1);
      rd(`DPC_OFF_STAT, 32'h1);
      m.pulse(s[1:0] + 2'h1);
      rd(`DPC_OFF_STAT, 32'h1);
      cap(s[1:0], 32'hF000_0100 + s, `DPC_OFF_PACT1, `DPC_OFF_PREF1);
      rd(`DPC_OFF_STAT, 32'h0);
      chk({31'h0, irq}, 32'h1);
      pos <= 32'sh0;
      m.pulse(s[1:0]);
      rd(`DPC_OFF_PACT1, 32'hF000_0100 + s);
      wr(`DPC_OFF_IRQ_STAT, 32'h1);
      rd(`DPC_OFF_IRQ_STAT, 32'h0);
      chk({31'h0, irq}, 32'h0);
    end
    // Missing setpoint encoder: armed but never fires
    sp_fit <= 1'b0;
    wr(`DPC_OFF_SRC, 32'h2);
    wr(`DPC_OFF_ARM, 32'h1);
    m.pulse(2'h2);
    rd(`DPC_OFF_STAT, 32'h1);
    rd(`DPC_OFF_PACT1, 32'hF000_0103);
    wr(`DPC_OFF_ARM, 32'h4001);
    rd(`DPC_OFF_STAT, 32'h0);
    sp_fit <= 1'b1;
    // Missing actual encoder: armed but never fires
    act_fit <= 1'b0;
    wr(`DPC_OFF_SRC, 32'h3);
    wr(`DPC_OFF_ARM, 32'h1);
    m.pulse(2'h3);
    rd(`DPC_OFF_STAT, 32'h1);
    rd(`DPC_OFF_PACT1, 32'hF000_0103);
    rd(`DPC_OFF_PREF1, ~32'hF000_0103);
    wr(`DPC_OFF_ARM, 32'h4001);
    rd(`DPC_OFF_STAT, 32'h0);
    act_fit <= 1'b1;
    // Channel two, falling edge, continuous, irq masked
    wr(`DPC_OFF_SRC, 32'h4);
    wr(`DPC_OFF_EDGE, 32'h0);
    wr(`DPC_OFF_ARM, 32'h8002);
    cap(2'h1, 32'h1234_5678, `DPC_OFF_PACT2, `DPC_OFF_PREF2);
    cap(2'h1, 32'h8765_4321, `DPC_OFF_PACT2, `DPC_OFF_PREF2);
    rd(`DPC_OFF_STAT, 32'h2);
    chk({31'h0, irq}, 32'h0);
    rd(`DPC_OFF_IRQ_STAT, 32'h2);
    wr(`DPC_OFF_IRQ_STAT, 32'h2);
    wr(`DPC_OFF_ARM, 32'h4000);
    rd(`DPC_OFF_STAT, 32'h2);
    wr(`DPC_OFF_ARM, 32'h4002);
    rd(`DPC_OFF_STAT, 32'h0);
    pos <= 32'sh0;
    m.pulse(2'h1);
    rd(`DPC_OFF_PACT2, 32'h8765_4321);
    results;
  end
endmodule // dpc_capture_bench
`default_nettype wire
